// ===== common/vrqs_defines.vh
// constants of the velocity ramp and quick-stop block
`ifndef VRQS_DEFINES_VH
`define VRQS_DEFINES_VH
// object indices
`define VRQS_IDX_ACCEL      16'h6048
`define VRQS_IDX_DECEL      16'h6049
`define VRQS_IDX_QSTOP      16'h604A
`define VRQS_IDX_UNIT       16'h604C
`define VRQS_IDX_QS_CODE    16'h605A
// sub-entries
`define VRQS_SUB_COUNT      8'h00
`define VRQS_SUB_FIRST      8'h01
`define VRQS_SUB_SECOND     8'h02
// reset values
`define VRQS_RST_COUNT      8'h02
`define VRQS_RST_ACC_SPEED  32'h000001F4
`define VRQS_RST_DEC_SPEED  32'h000001F4
`define VRQS_RST_QS_SPEED   32'h00001388
`define VRQS_RST_TIME       16'h0001
`define VRQS_RST_UNIT_MUL   32'h00000001
`define VRQS_RST_UNIT_DIV   32'h00000001
`define VRQS_RST_QS_CODE    16'h0002
// quick-stop action codes
`define VRQS_QS_IMMEDIATE   16'h0000
`define VRQS_QS_SLOW        16'h0001
`define VRQS_QS_QUICK       16'h0002
`define VRQS_QS_SLOW_HOLD   16'h0005
`define VRQS_QS_QUICK_HOLD  16'h0006
// timing: one time unit of the ramp records
`define VRQS_CLK_NS         40
`define VRQS_TIME_UNIT_NS   1000000
`define VRQS_TICK_CYCLES    (`VRQS_TIME_UNIT_NS / `VRQS_CLK_NS)
// speed limit of the 16-bit demand
`define VRQS_DEMAND_MAX     32'h00007FFF
// divider steps for the rpm conversion
`define VRQS_DIV_STEPS      7'h40
`endif

// ===== core/vrqs_top.v
// velocity ramp generator with quick-stop reaction and parameter objects
//
// Behaviour
// - rising speed ramps with the acceleration record, speed step per time step.
// - normal slowing ramps with the separate deceleration record.
// - quick stop in velocity mode with codes 2 and 6 ramps with its own dedicated record.
// - ramp rate is sub-entry 01 speed change over sub-entry 02 time change.
// - velocity parameters are in the unit set by the speed unit factor.
// - rpm equals internal speed times signed multiplier over signed divisor.
// - action code, signed 16 bit, default 2, applied on each quick-stop entry.
// - code 0 stops at once and requests switch on disabled in the same cycle.
// - code 1 brakes on the deceleration ramp, then switch on disabled.
// - code 2 brakes on the quick-stop ramp, then switch on disabled.
// - target outside min or max is clamped and the internal limit flag set.
`include "vrqs_defines.vh"
`default_nettype none
module vrqs_top #(
    parameter [31:0] TICK_CYCLES = `VRQS_TICK_CYCLES
) (
    // clock and reset
    input  wire        clk,
    input  wire        srst,
    // object dictionary access
    input  wire [15:0] od_index,
    input  wire [7:0]  od_sub,
    input  wire        od_wr,
    input  wire        od_rd,
    input  wire [31:0] od_wdata,
    output reg  [31:0] od_rdata,
    output reg         od_ack,
    output reg         od_err,
    // velocity mode inputs
    input  wire        velocity_mode,
    input  wire [15:0] target_velocity,
    input  wire [31:0] vel_min_amount,
    input  wire [31:0] vel_max_amount,
    input  wire        quick_stop_enter,
    input  wire        resume_operation,
    // drive outputs
    output reg  [15:0] velocity_demand,
    output reg  [31:0] demand_rpm,
    output reg         internal_limit_flag,
    output reg         quick_stop_busy,
    output reg         motor_energized,
    output reg         switch_on_disabled_req
);

localparam [1:0] S_RUN  = 2'h0;
localparam [1:0] S_RAMP = 2'h1;
localparam [1:0] S_HOLD = 2'h2;
localparam [1:0] S_OFF  = 2'h3;

reg [31:0] accel_speed_step;
reg [15:0] accel_time_step;
reg [31:0] decel_speed_step;
reg [15:0] decel_time_step;
reg [31:0] qstop_ramp_speed_step;
reg [15:0] qstop_ramp_time_step;
reg [31:0] speed_unit_multiplier;
reg [31:0] speed_unit_divisor;
reg [15:0] quick_stop_action_code;

reg [1:0]  state;
reg [15:0] qs_code;
reg [31:0] demand;
reg [31:0] tick_cnt;
reg [15:0] time_cnt;

////////////////////////////////////////////////////////////////////////////////
// object access

reg        hit;
reg        ro_hit;
reg [31:0] rd_val;
always @* begin
    hit    = 1'b1;
    ro_hit = 1'b0;
    rd_val = 32'h00000000;
    if (od_sub == `VRQS_SUB_COUNT && (od_index == `VRQS_IDX_ACCEL ||
        od_index == `VRQS_IDX_DECEL || od_index == `VRQS_IDX_QSTOP ||
        od_index == `VRQS_IDX_UNIT)) begin
        ro_hit = 1'b1;
        rd_val = {24'h000000, `VRQS_RST_COUNT};
    end else if (od_index == `VRQS_IDX_QS_CODE && od_sub == `VRQS_SUB_COUNT) begin
        rd_val = {{16{quick_stop_action_code[15]}}, quick_stop_action_code};
    end else if (od_sub == `VRQS_SUB_FIRST) begin
        case (od_index)
            `VRQS_IDX_ACCEL: rd_val = accel_speed_step;
            `VRQS_IDX_DECEL: rd_val = decel_speed_step;
            `VRQS_IDX_QSTOP: rd_val = qstop_ramp_speed_step;
            `VRQS_IDX_UNIT:  rd_val = speed_unit_multiplier;
            default:         hit = 1'b0;
        endcase
    end else if (od_sub == `VRQS_SUB_SECOND) begin
        case (od_index)
            `VRQS_IDX_ACCEL: rd_val = {16'h0000, accel_time_step};
            `VRQS_IDX_DECEL: rd_val = {16'h0000, decel_time_step};
            `VRQS_IDX_QSTOP: rd_val = {16'h0000, qstop_ramp_time_step};
            `VRQS_IDX_UNIT:  rd_val = speed_unit_divisor;
            default:         hit = 1'b0;
        endcase
    end else begin
        hit = 1'b0;
    end
end

always @(posedge clk) begin
    if (srst) begin
        accel_speed_step       <= `VRQS_RST_ACC_SPEED;
        accel_time_step        <= `VRQS_RST_TIME;
        decel_speed_step       <= `VRQS_RST_DEC_SPEED;
        decel_time_step        <= `VRQS_RST_TIME;
        qstop_ramp_speed_step  <= `VRQS_RST_QS_SPEED;
        qstop_ramp_time_step   <= `VRQS_RST_TIME;
        speed_unit_multiplier  <= `VRQS_RST_UNIT_MUL;
        speed_unit_divisor     <= `VRQS_RST_UNIT_DIV;
        quick_stop_action_code <= `VRQS_RST_QS_CODE;
        od_rdata               <= 32'h00000000;
        od_ack                 <= 1'b0;
        od_err                 <= 1'b0;
    end else begin
        od_ack <= od_wr | od_rd;
        od_err <= (od_wr | od_rd) & (~hit | (od_wr & ro_hit));
        if (od_rd) begin
            od_rdata <= hit ? rd_val : 32'h00000000;
        end
        if (od_wr && hit && !ro_hit) begin
            if (od_sub == `VRQS_SUB_FIRST) begin
                case (od_index)
                    `VRQS_IDX_ACCEL: accel_speed_step      <= od_wdata;
                    `VRQS_IDX_DECEL: decel_speed_step      <= od_wdata;
                    `VRQS_IDX_QSTOP: qstop_ramp_speed_step <= od_wdata;
                    `VRQS_IDX_UNIT:  speed_unit_multiplier <= od_wdata;
                    default: ;
                endcase
            end else if (od_sub == `VRQS_SUB_SECOND) begin
                case (od_index)
                    `VRQS_IDX_ACCEL: accel_time_step      <= od_wdata[15:0];
                    `VRQS_IDX_DECEL: decel_time_step      <= od_wdata[15:0];
                    `VRQS_IDX_QSTOP: qstop_ramp_time_step <= od_wdata[15:0];
                    `VRQS_IDX_UNIT:  speed_unit_divisor   <= od_wdata;
                    default: ;
                endcase
            end else begin
                // any value is stored; reserved codes act as the default
                quick_stop_action_code <= od_wdata[15:0];
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// target clamping

reg [31:0] tgt_abs;
reg [31:0] tgt_mag;
reg [31:0] tgt_clamped;
reg        tgt_limited;
always @* begin
    tgt_abs = target_velocity[15] ? 32'h00000000 - {{16{1'b1}}, target_velocity}
                                  : {16'h0000, target_velocity};
    tgt_limited = 1'b0;
    tgt_mag = tgt_abs;
    if (tgt_abs < vel_min_amount) begin
        tgt_mag     = vel_min_amount;
        tgt_limited = 1'b1;
    end else if (tgt_abs > vel_max_amount) begin
        tgt_mag     = vel_max_amount;
        tgt_limited = 1'b1;
    end
    // the demand port is 16 bits signed, so clamp there too
    if (tgt_mag > `VRQS_DEMAND_MAX) begin
        tgt_mag = `VRQS_DEMAND_MAX;
    end
    tgt_clamped = target_velocity[15] ? 32'h00000000 - tgt_mag : tgt_mag;
end

////////////////////////////////////////////////////////////////////////////////
// ramp rate selection and step

wire        qs_slow = (qs_code == `VRQS_QS_SLOW) || (qs_code == `VRQS_QS_SLOW_HOLD);
wire        qs_hold = (qs_code == `VRQS_QS_SLOW_HOLD) || (qs_code == `VRQS_QS_QUICK_HOLD);
wire [31:0] eff_target = (state == S_RUN) ? tgt_clamped : 32'h00000000;
wire [32:0] diff = {eff_target[31], eff_target} - {demand[31], demand};
wire [32:0] abs_diff = diff[32] ? 33'h000000000 - diff : diff;
wire        away = (demand == 32'h00000000) || (diff[32] == demand[31]);

reg [31:0] sel_speed;
reg [15:0] sel_time;
always @* begin
    if (state == S_RAMP && !qs_slow) begin
        sel_speed = qstop_ramp_speed_step;
        sel_time  = qstop_ramp_time_step;
    end else if (state == S_RUN && away) begin
        sel_speed = accel_speed_step;
        sel_time  = accel_time_step;
    end else begin
        sel_speed = decel_speed_step;
        sel_time  = decel_time_step;
    end
end

// a zero time step would stall the ramp, so it counts as one unit
wire [15:0] time_lim = (sel_time == 16'h0000) ? 16'h0001 : sel_time;
wire        unit_tick = (tick_cnt >= TICK_CYCLES - 32'h00000001);
wire        step_due = unit_tick && (time_cnt + 16'h0001 >= time_lim);
wire        moving = velocity_mode && (state == S_RUN || state == S_RAMP);
wire [31:0] next_demand = (abs_diff <= {1'b0, sel_speed}) ? eff_target :
                          diff[32] ? demand - sel_speed : demand + sel_speed;

////////////////////////////////////////////////////////////////////////////////
// quick-stop reaction and demand

always @(posedge clk) begin
    if (srst) begin
        state                  <= S_RUN;
        qs_code                <= `VRQS_RST_QS_CODE;
        demand                 <= 32'h00000000;
        tick_cnt               <= 32'h00000000;
        time_cnt               <= 16'h0000;
        velocity_demand        <= 16'h0000;
        internal_limit_flag    <= 1'b0;
        quick_stop_busy        <= 1'b0;
        motor_energized        <= 1'b1;
        switch_on_disabled_req <= 1'b0;
    end else begin
        switch_on_disabled_req <= 1'b0;
        internal_limit_flag    <= velocity_mode & tgt_limited;
        tick_cnt <= unit_tick ? 32'h00000000 : tick_cnt + 32'h00000001;
        if (!moving) begin
            time_cnt <= 16'h0000;
        end else if (step_due) begin
            time_cnt <= 16'h0000;
            demand   <= next_demand;
        end else if (unit_tick) begin
            time_cnt <= time_cnt + 16'h0001;
        end
        case (state)
            S_RUN: begin
                if (quick_stop_enter) begin
                    time_cnt <= 16'h0000;
                    case (quick_stop_action_code)
                        `VRQS_QS_IMMEDIATE: begin
                            demand                 <= 32'h00000000;
                            state                  <= S_OFF;
                            motor_energized        <= 1'b0;
                            switch_on_disabled_req <= 1'b1;
                            qs_code                <= quick_stop_action_code;
                        end
                        `VRQS_QS_SLOW, `VRQS_QS_QUICK, `VRQS_QS_SLOW_HOLD,
                        `VRQS_QS_QUICK_HOLD: begin
                            state   <= S_RAMP;
                            qs_code <= quick_stop_action_code;
                        end
                        default: begin
                            state   <= S_RAMP;
                            qs_code <= `VRQS_QS_QUICK;
                        end
                    endcase
                end
            end
            S_RAMP: begin
                if (demand == 32'h00000000) begin
                    if (qs_hold) begin
                        state <= S_HOLD;
                    end else begin
                        state                  <= S_OFF;
                        motor_energized        <= 1'b0;
                        switch_on_disabled_req <= 1'b1;
                    end
                end
            end
            S_HOLD: begin
                if (resume_operation) begin
                    state <= S_RUN;
                end
            end
            S_OFF: begin
                if (resume_operation) begin
                    state           <= S_RUN;
                    motor_energized <= 1'b1;
                end
            end
            default: state <= S_RUN;
        endcase
        quick_stop_busy <= (state != S_RUN) || quick_stop_enter;
        velocity_demand <= demand[15:0];
    end
end

////////////////////////////////////////////////////////////////////////////////
// rpm conversion: serial divide of demand times multiplier

wire [63:0] product = $signed(demand) * $signed(speed_unit_multiplier);
wire [63:0] prod_abs = product[63] ? 64'h0000000000000000 - product : product;
wire [31:0] den_abs = speed_unit_divisor[31] ? 32'h00000000 - speed_unit_divisor
                                             : speed_unit_divisor;
reg  [6:0]  div_cnt;
reg  [32:0] div_rem;
reg  [63:0] div_q;
reg  [31:0] div_den;
reg         div_neg;
wire [32:0] rem_sh = {div_rem[31:0], div_q[63]};
wire        rem_ge = rem_sh >= {1'b0, div_den};

always @(posedge clk) begin
    if (srst) begin
        div_cnt    <= 7'h00;
        div_rem    <= 33'h000000000;
        div_q      <= 64'h0000000000000000;
        div_den    <= 32'h00000000;
        div_neg    <= 1'b0;
        demand_rpm <= 32'h00000000;
    end else if (div_cnt == 7'h00) begin
        // a new conversion starts whenever the last one ends
        div_cnt <= `VRQS_DIV_STEPS;
        div_rem <= 33'h000000000;
        div_q   <= prod_abs;
        div_den <= den_abs;
        div_neg <= product[63] ^ speed_unit_divisor[31];
    end else begin
        div_cnt <= div_cnt - 7'h01;
        div_rem <= rem_ge ? rem_sh - {1'b0, div_den} : rem_sh;
        div_q   <= {div_q[62:0], rem_ge};
        if (div_cnt == 7'h01) begin
            // divisor zero gives zero rather than a garbage quotient
            if (div_den == 32'h00000000) begin
                demand_rpm <= 32'h00000000;
            end else if (div_neg) begin
                demand_rpm <= 32'h00000000 - {div_q[30:0], rem_ge};
            end else begin
                demand_rpm <= {div_q[30:0], rem_ge};
            end
        end
    end
end

endmodule // vrqs_top
`default_nettype wire

// ===== tb/vrqs_host.sv
// fieldbus host model issuing object reads and writes
`default_nettype none
module vrqs_host (
    // clock
    input  wire logic        clk,
    // object access
    output logic      [15:0] od_index,
    output logic      [7:0]  od_sub,
    output logic             od_wr,
    output logic             od_rd,
    output logic      [31:0] od_wdata,
    input  wire logic [31:0] od_rdata,
    input  wire logic        od_ack,
    input  wire logic        od_err
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        od_index = 16'h0000;
        od_sub = 8'h00;
        od_wr = 1'b0;
        od_rd = 1'b0;
        od_wdata = 32'h00000000;
    end
    // one-cycle strobe; address and data scrambled once released
    task automatic access(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                          input logic [31:0] d, output logic [31:0] q, output logic e,
                          output logic a);
        @(negedge clk);
        od_index = idx;
        od_sub = sub;
        od_wdata = d;
        od_wr = w;
        od_rd = ~w;
        @(negedge clk);
        // acknowledge stands for one cycle only, so take the answer before release
        q = od_rdata;
        e = od_err;
        a = od_ack;
        od_wr = 1'b0;
        od_rd = 1'b0;
        od_index = ~idx;
        od_sub = ~sub;
        od_wdata = ~d;
    endtask
endmodule // vrqs_host
`default_nettype wire

// ===== tb/vrqs_top_chk.sv
// port checker of the velocity ramp and quick-stop block
`default_nettype none
module vrqs_top_chk #(
    parameter [31:0] TICK_CYCLES = 32'h00000004
) (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic [15:0] od_index,
    input wire logic [7:0]  od_sub,
    input wire logic        od_wr,
    input wire logic        od_rd,
    input wire logic [31:0] od_wdata,
    input wire logic [31:0] od_rdata,
    input wire logic        od_ack,
    input wire logic        od_err,
    input wire logic        velocity_mode,
    input wire logic [15:0] target_velocity,
    input wire logic [31:0] vel_min_amount,
    input wire logic [31:0] vel_max_amount,
    input wire logic        quick_stop_enter,
    input wire logic        resume_operation,
    input wire logic [15:0] velocity_demand,
    input wire logic [31:0] demand_rpm,
    input wire logic        internal_limit_flag,
    input wire logic        quick_stop_busy,
    input wire logic        motor_energized,
    input wire logic        switch_on_disabled_req
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mag;
    logic        out_lim;
    always_comb begin
        mag = {16'h0000, target_velocity[15] ? -target_velocity : target_velocity};
        out_lim = (mag > vel_max_amount) || (mag < vel_min_amount);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    AST_ACK_NEXT: assert property ((od_wr || od_rd) |=> od_ack)
        else $error("object access not acknowledged");
    AST_ERR_ACK: assert property (od_err |-> od_ack)
        else $error("error without acknowledge");
    AST_RDATA_HOLD: assert property (!od_rd |=> $stable(od_rdata))
        else $error("read data moved without a read");
    // the demand output lags the internal demand by one cycle
    AST_SOD_OFF: assert property (switch_on_disabled_req |->
        !motor_energized ##1 velocity_demand == 16'h0000)
        else $error("switch off request while moving or energized");
    AST_SOD_PULSE: assert property (switch_on_disabled_req |=> !switch_on_disabled_req)
        else $error("switch off request longer than one cycle");
    AST_ENTER_BUSY: assert property (quick_stop_enter && !quick_stop_busy |=> quick_stop_busy)
        else $error("quick stop entry not taken");
    AST_KEEP_ENERGIZED: assert property ($fell(motor_energized) |-> switch_on_disabled_req)
        else $error("motor released without switch off request");
    AST_STEP_GAP: assert property ($changed(velocity_demand) && !quick_stop_busy && !quick_stop_enter
        |=> ($stable(velocity_demand) || quick_stop_busy)[*3])
        else $error("demand stepped faster than one time unit");
    AST_LIMIT_SET: assert property ((velocity_mode && out_lim)[*3] |-> internal_limit_flag)
        else $error("clamped target without limit flag");
    cover property (switch_on_disabled_req);
    cover property ($rose(internal_limit_flag));
    cover property (od_err);
endmodule // vrqs_top_chk
bind vrqs_top vrqs_top_chk #(.TICK_CYCLES(TICK_CYCLES)) i_chk (.clk, .srst, .od_index, .od_sub,
    .od_wr, .od_rd, .od_wdata, .od_rdata, .od_ack, .od_err, .velocity_mode, .target_velocity,
    .vel_min_amount, .vel_max_amount, .quick_stop_enter, .resume_operation, .velocity_demand,
    .demand_rpm, .internal_limit_flag, .quick_stop_busy, .motor_energized,
    .switch_on_disabled_req);
`default_nettype wire

// ===== tb/tb_velocity_ramp_quick_stop.sv
// self-checking bench of the velocity ramp and quick-stop block
`default_nettype none
module tb_velocity_ramp_quick_stop;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, srst, od_wr, od_rd, od_ack, od_err, velocity_mode, quick_stop_enter;
    logic        resume_operation, internal_limit_flag, quick_stop_busy, motor_energized;
    logic        switch_on_disabled_req, e, a;
    logic [7:0]  od_sub;
    logic [15:0] od_index, target_velocity, velocity_demand;
    logic [31:0] od_wdata, od_rdata, vel_min_amount, vel_max_amount, demand_rpm, q, wv;
    logic [31:0] spd [3];
    int          n_errors, check_count, seed, model, k, mul, dv;
    logic [15:0] base [5] = '{16'h6048, 16'h6049, 16'h604A, 16'h604C, 16'h605A};
    logic [15:0] codes [5] = '{16'h0000, 16'h0001, 16'h0002, 16'h0005, 16'h0006};
    logic [31:0] rst [14] = '{32'h2, 32'h1F4, 32'h1, 32'h2, 32'h1F4, 32'h1, 32'h2, 32'h1388,
                              32'h1, 32'h2, 32'h1, 32'h1, 32'h2, 32'h0};
    vrqs_top #(.TICK_CYCLES(32'h4)) i_dut (.clk, .srst, .od_index, .od_sub, .od_wr, .od_rd,
        .od_wdata, .od_rdata, .od_ack, .od_err, .velocity_mode, .target_velocity,
        .vel_min_amount, .vel_max_amount, .quick_stop_enter, .resume_operation,
        .velocity_demand, .demand_rpm, .internal_limit_flag, .quick_stop_busy,
        .motor_energized, .switch_on_disabled_req);
    vrqs_host i_host (.clk, .od_index, .od_sub, .od_wr, .od_rd, .od_wdata, .od_rdata, .od_ack,
        .od_err);
    ////////////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] idx, input logic [7:0] sub,
                       input logic [31:0] d, input logic err_exp);
        i_host.access(w, idx, sub, d, q, e, a);
        chk("od_ack", 32'h1, {31'h0, a});
        chk("od_err", {31'h0, err_exp}, {31'h0, e});
    endtask
    // reference ramp: one bounded step per change, landing on the target
    task automatic step_to(input int tgt, input int stp);
        logic [15:0] last;
        while (model != tgt) begin
            last = velocity_demand;
            model = (tgt > model) ? ((model + stp > tgt) ? tgt : model + stp)
                                  : ((model - stp < tgt) ? tgt : model - stp);
            for (k = 0; k < 100 && velocity_demand === last; k++)
                @(negedge clk);
            chk("velocity_demand", model, {{16{velocity_demand[15]}}, velocity_demand});
        end
    endtask
    task automatic summarize();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 60000);
        n_errors++;
        summarize();
    end
    initial begin
        seed = 45690;
        srst = 1'b1;
        velocity_mode = 1'b1;
        target_velocity = 16'h0000;
        vel_min_amount = 32'h00000000;
        vel_max_amount = 32'h00007530;
        quick_stop_enter = 1'b0;
        resume_operation = 1'b0;
        repeat (10) @(negedge clk);
        srst = 1'b0;
        // presets, last one an unmapped sub-entry
        for (int i = 0; i < 14; i++) begin
            acc(1'b0, base[i / 3], 8'(i % 3), 32'h0, i == 13);
            chk("preset", rst[i], q);
        end
        acc(1'b1, 16'h6048, 8'h00, 32'h5, 1'b1);
        acc(1'b0, 16'h6048, 8'h00, 32'h0, 1'b0);
        chk("count", 32'h2, q);
        for (int i = 0; i < 9; i++) begin
            wv = $random(seed);
            if (i % 2 == 1 && i < 6) wv[31:16] = 16'h0000;
            acc(1'b1, base[i / 2], (i == 8) ? 8'h00 : 8'(i % 2 + 1), wv, 1'b0);
            acc(1'b0, base[i / 2], (i == 8) ? 8'h00 : 8'(i % 2 + 1), 32'h0, 1'b0);
            chk("readback", (i == 8) ? {{16{wv[15]}}, wv[15:0]} : wv, q);
        end
        // small rates with distinct time steps keep the run short
        for (int r = 0; r < 3; r++) begin
            spd[r] = 32'd100 + ($unsigned($random(seed)) % 200);
            acc(1'b1, base[r], 8'h01, spd[r], 1'b0);
            acc(1'b1, base[r], 8'h02, 32'(r + 1), 1'b0);
        end
        mul = $random(seed) % 50;
        dv = 1 + $unsigned($random(seed)) % 9;
        acc(1'b1, 16'h604C, 8'h01, mul, 1'b0);
        acc(1'b1, 16'h604C, 8'h02, dv, 1'b0);
        target_velocity = 16'd1000;
        step_to(1000, spd[0]);
        target_velocity = 16'd300;
        step_to(300, spd[1]);
        repeat (200) @(negedge clk);
        chk("demand_rpm", 300 * mul / dv, demand_rpm);
        vel_max_amount = 32'd800;
        target_velocity = 16'd1000;
        step_to(800, spd[0]);
        chk("internal_limit_flag", 32'h1, {31'h0, internal_limit_flag});
        vel_max_amount = 32'h00007530;
        step_to(1000, spd[0]);
        chk("internal_limit_flag", 32'h0, {31'h0, internal_limit_flag});
        foreach (codes[c]) begin
            acc(1'b1, 16'h605A, 8'h00, {16'h0000, codes[c]}, 1'b0);
            quick_stop_enter = 1'b1;
            @(negedge clk);
            quick_stop_enter = 1'b0;
            step_to(0, (c == 0) ? 1000 : (codes[c] % 4 == 1) ? spd[1] : spd[2]);
            repeat (3) @(negedge clk);
            chk("motor_energized", {31'h0, codes[c] > 16'h2}, {31'h0, motor_energized});
            chk("quick_stop_busy", 32'h1, {31'h0, quick_stop_busy});
            target_velocity = 16'h0000;
            resume_operation = 1'b1;
            @(negedge clk);
            resume_operation = 1'b0;
            @(negedge clk);
            chk("resume", 32'h1, {31'h0, motor_energized & ~quick_stop_busy});
            target_velocity = 16'd1000;
            step_to(1000, spd[0]);
        end
        summarize();
    end
endmodule // tb_velocity_ramp_quick_stop
`default_nettype wire
